//--- hdl/gain_mem_if.sv
`timescale 1ns/100ps
`default_nettype none
interface gain_mem_if #(parameter int AW = 4, parameter int DW = 16);
  logic we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr,
    input rdata);
  modport mem (input we, input waddr, input wdata, input raddr,
    output rdata);
endinterface : gain_mem_if
`default_nettype wire

//--- hdl/gain_store.sv
`timescale 1ns/100ps
`default_nettype none
module gain_store #(
  parameter int AW = 4,
  parameter int DW = 16,
  parameter int DEPTH = 9
) (
  input wire logic CLOCK,
  gain_mem_if.mem bus
);
  logic [DW-1:0] mem_reg [0:DEPTH-1];
  logic [DW-1:0] rdata_reg;

  // one write port, registered read data
  always_ff @(posedge CLOCK)
  begin
    if (bus.we)
    begin
      mem_reg[bus.waddr] <= bus.wdata;
    end
    rdata_reg <= mem_reg[bus.raddr];
  end

  assign bus.rdata = rdata_reg;
endmodule : gain_store
`default_nettype wire

//--- hdl/supply_cmd.sv
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "supply_cmd_defines.svh"
module supply_cmd #(
  parameter int UNITS = 8
) (
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [UNITS*32-1:0] MEAS_VOLTAGE,
  input wire logic [3:0] UNIT_COUNT,
  input wire logic SERIES_MODE,
  input wire logic [31:0] RATED_VOLTAGE,
  input wire logic [31:0] RATED_POWER,
  input wire logic [31:0] RES_MIN,
  input wire logic [31:0] RES_MAX,
  input wire logic [31:0] FW_VERSION,
  input wire logic [31:0] FW_DATE,
  input wire logic [8:0] PORT_TYPE,
  output logic [31:0] OVP_LIMIT,
  output logic [31:0] POWER_LIMIT,
  output logic [31:0] POWER_TOTAL,
  output logic [31:0] SOURCE_RES,
  output logic [188:0] PORT_CONFIG,
  output logic [2:0] PORT_APPLY,
  output logic SAVE_SETUP,
  output logic CMD_BUSY
);
  supply_cmd_pkg::core_s r_reg;
  supply_cmd_pkg::core_s r_next;
  supply_cmd_pkg::port_s ps;
  logic [3:0] idx;
  logic [1:0] pi;
  logic [2:0] ptype;
  logic [3:0] k;
  gain_mem_if #(.AW(4), .DW(16)) gm ();

  gain_store #(.AW(4), .DW(16), .DEPTH(9)) u_gains (
    .CLOCK(CLOCK),
    .bus(gm.mem)
  );

  // memory port straight from state flops
  assign gm.we = r_reg.we;
  assign gm.waddr = r_reg.waddr;
  assign gm.wdata = r_reg.mwdata;
  assign gm.raddr = r_reg.raddr;

  // byte-lane merge of a write into a word
  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] v;
    v = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        v[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return v;
  endfunction : merge

  // reading of one unit
  function automatic logic [31:0] pick(input logic [UNITS*32-1:0] v,
    input logic [3:0] i);
    logic [31:0] s;
    s = 32'h0;
    for (int u = 0; u < UNITS; u++)
    begin
      if (u[3:0] == i)
      begin
        s = v[u*32 +: 32];
      end
    end
    return s;
  endfunction : pick

  // sum of the first n units
  function automatic logic [31:0] sum_units(input logic [UNITS*32-1:0] v,
    input logic [3:0] n);
    logic [31:0] s;
    s = 32'h0;
    for (int u = 0; u < UNITS; u++)
    begin
      if (u[3:0] < n)
      begin
        s = s + v[u*32 +: 32];
      end
    end
    return s;
  endfunction : sum_units

  // allowed baud rates
  function automatic logic baud_ok(input logic [31:0] b);
    case (b)
      32'h000004B0, 32'h00000960, 32'h000012C0, 32'h00002580,
      32'h00003840, 32'h00004B00, 32'h00009600, 32'h0000E100,
      32'h0000F424, 32'h0001C200: baud_ok = 1'b1;
      default: baud_ok = 1'b0;
    endcase
  endfunction : baud_ok

  // state at reset
  function automatic supply_cmd_pkg::core_s reset_state();
    supply_cmd_pkg::core_s v;
    v = '0;
    v.st = supply_cmd_pkg::ST_IDLE;
    for (int p = 0; p < `PORTS; p++)
    begin
      v.port[p].baud = `BAUD_RST;
      v.port[p].parity = `CH_NONE;
      v.port[p].dbits = `DBITS_RST;
      v.port[p].sbits = `SBITS_RST;
      v.port[p].flow = `CH_NONE;
      v.port[p].echo = `CH_ECHO;
      v.port[p].tmo = `TMO_RST;
    end
    v.awready = 1'b1;
    v.wready = 1'b1;
    v.arready = 1'b1;
    return v;
  endfunction : reset_state

  // command fields of the latched command word
  assign idx = r_reg.cmd[`CMD_IDX_LSB +: 4];
  assign pi = 2'(idx - 4'h1);
  assign ptype = PORT_TYPE[pi*3 +: 3];

  // bus slave, then command engine; engine sets win over bus clears
  always_comb
  begin
    r_next = r_reg;
    ps = r_reg.port[pi];
    k = 4'(r_reg.cnt - 4'h2);
    r_next.apply = 3'h0;
    r_next.save = 1'b0;
    r_next.we = 1'b0;
    if (S_AXI_AWVALID && r_reg.awready)
    begin
      r_next.aw_have = 1'b1;
      r_next.awaddr = {S_AXI_AWADDR[7:2], 2'h0};
    end
    if (S_AXI_WVALID && r_reg.wready)
    begin
      r_next.w_have = 1'b1;
      r_next.wdata = S_AXI_WDATA;
      r_next.wstrb = S_AXI_WSTRB;
    end
    if (S_AXI_BREADY && r_reg.bvalid)
    begin
      r_next.bvalid = 1'b0;
    end
    // register write once address and data are both held
    if (r_reg.aw_have && r_reg.w_have && !r_reg.bvalid)
    begin
      r_next.aw_have = 1'b0;
      r_next.w_have = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp = `RESP_OKAY;
      if (r_reg.awaddr == `REG_CMD)
      begin
        if (r_reg.busy)
        begin
          r_next.bresp = `RESP_SLVERR;
        end
        else
        begin
          r_next.cmd = r_reg.wdata[11:0];
          r_next.busy = 1'b1;
          r_next.done = 1'b0;
          r_next.cmd_err = 1'b0;
          r_next.st = supply_cmd_pkg::ST_EXEC;
        end
      end
      else if (r_reg.awaddr >= `REG_ARG0 && r_reg.awaddr <= `REG_ARG3)
      begin
        r_next.arg[r_reg.awaddr[3:2] - 2'h1] = merge(
          r_reg.arg[r_reg.awaddr[3:2] - 2'h1], r_reg.wdata, r_reg.wstrb);
      end
      else if (r_reg.awaddr == `REG_STATUS)
      begin
        if (r_reg.wdata[`STAT_DONE])
        begin
          r_next.done = 1'b0;
        end
      end
      else if (r_reg.awaddr == `REG_EVENT)
      begin
        if (r_reg.wdata[`EVT_RANGE_ERR])
        begin
          r_next.range_err = 1'b0;
        end
      end
      else if (!(r_reg.awaddr >= `REG_RES0 && r_reg.awaddr <= `REG_RES4))
      begin
        r_next.bresp = `RESP_SLVERR;
      end
    end
    // register read
    if (S_AXI_RREADY && r_reg.rvalid)
    begin
      r_next.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID && r_reg.arready)
    begin
      r_next.rvalid = 1'b1;
      r_next.rresp = `RESP_OKAY;
      r_next.rdata = 32'h0;
      if (S_AXI_ARADDR[7:2] == `REG_CMD >> 2)
      begin
        r_next.rdata = {20'h0, r_reg.cmd};
      end
      else if (S_AXI_ARADDR >= `REG_ARG0 && S_AXI_ARADDR < `REG_RES0)
      begin
        r_next.rdata = r_reg.arg[S_AXI_ARADDR[3:2] - 2'h1];
      end
      else if (S_AXI_ARADDR >= `REG_RES0 && S_AXI_ARADDR < `REG_STATUS)
      begin
        r_next.rdata = r_reg.res[3'(S_AXI_ARADDR[7:2] - 6'h05)];
      end
      else if (S_AXI_ARADDR[7:2] == `REG_STATUS >> 2)
      begin
        r_next.rdata = {16'h0, r_reg.unit, 5'h0, r_reg.cmd_err,
          r_reg.done, r_reg.busy};
      end
      else if (S_AXI_ARADDR[7:2] == `REG_EVENT >> 2)
      begin
        r_next.rdata[`EVT_RANGE_ERR] = r_reg.range_err;
      end
      else
      begin
        r_next.rresp = `RESP_SLVERR;
      end
    end
    // command engine
    case (r_reg.st)
      supply_cmd_pkg::ST_IDLE:
      begin
        r_next.cnt = 4'h0;
      end
      supply_cmd_pkg::ST_EXEC:
      begin
        r_next.st = supply_cmd_pkg::ST_IDLE;
        r_next.busy = 1'b0;
        r_next.done = 1'b1;
        r_next.unit = `UNIT_NONE;
        case (r_reg.cmd[`CMD_OP_LSB +: 4])
          supply_cmd_pkg::OP_MEASURE:
          begin
            r_next.unit = `UNIT_VOLT;
            if (r_reg.cmd[`CMD_HAS_IDX])
            begin
              if (idx < UNIT_COUNT)
              begin
                r_next.res[0] = pick(MEAS_VOLTAGE, idx);
              end
              else
              begin
                r_next.cmd_err = 1'b1;
              end
            end
            else if (SERIES_MODE && UNIT_COUNT > 4'h1)
            begin
              r_next.res[0] = sum_units(MEAS_VOLTAGE, UNIT_COUNT);
            end
            else
            begin
              r_next.res[0] = pick(MEAS_VOLTAGE, 4'h0);
            end
          end
          supply_cmd_pkg::OP_VERSION:
          begin
            r_next.res[0] = FW_VERSION;
            r_next.res[1] = FW_DATE;
          end
          supply_cmd_pkg::OP_OVP:
          begin
            r_next.unit = `UNIT_VOLT;
            if (!r_reg.cmd[`CMD_HAS_ARG])
            begin
              r_next.res[0] = r_reg.overvoltage_limit_cmd;
            end
            else if ({3'h0, r_reg.arg[0]} * `OVP_DEN >
              {3'h0, RATED_VOLTAGE} * `OVP_NUM)
            begin
              r_next.range_err = 1'b1;
            end
            else
            begin
              r_next.overvoltage_limit_cmd = r_reg.arg[0];
            end
          end
          supply_cmd_pkg::OP_POWER:
          begin
            r_next.unit = `UNIT_WATT;
            if (!r_reg.cmd[`CMD_HAS_ARG])
            begin
              r_next.res[0] = r_reg.plim;
            end
            else if (r_reg.arg[0] > RATED_POWER)
            begin
              r_next.range_err = 1'b1;
            end
            else
            begin
              r_next.plim = r_reg.arg[0];
              r_next.ptot = UNIT_COUNT * r_reg.arg[0];
            end
          end
          supply_cmd_pkg::OP_PORT:
          begin
            if (idx == 4'h0 || idx > `PORTS)
            begin
              r_next.cmd_err = 1'b1;
            end
            else if (!r_reg.cmd[`CMD_HAS_ARG])
            begin
              r_next.res[0] = {29'h0, ptype};
              r_next.res[1] = {15'h0, ps.baud};
              r_next.res[2] = {ps.flow, 2'h0, ps.sbits, ps.dbits,
                ps.parity, 8'h0};
              r_next.res[3] = {8'h0, ps.echo, ps.tmo};
              if (ptype == `PT_EMPTY)
              begin
                r_next.res[1] = `EMPTY_HI;
                r_next.res[2] = `EMPTY_LO;
                r_next.res[3] = 32'h0;
              end
            end
            else if (ptype == `PT_EMPTY || ptype == `PT_GPIB ||
              ptype == `PT_LAN)
            begin
              r_next.cmd_err = 1'b1;
            end
            else if (!baud_ok(r_reg.arg[0]) ||
              !(r_reg.arg[1][7:0] == `CH_ODD ||
                r_reg.arg[1][7:0] == `CH_EVEN ||
                r_reg.arg[1][7:0] == `CH_NONE) ||
              !(r_reg.arg[1][15:8] == 8'h07 ||
                r_reg.arg[1][15:8] == 8'h08) ||
              !(r_reg.arg[1][23:16] == 8'h01 ||
                r_reg.arg[1][23:16] == 8'h02) ||
              (ptype == `PT_RS485 && r_reg.arg[2] > `TMO_MAX_MS) ||
              (ptype != `PT_RS485 &&
                (!(r_reg.arg[1][31:24] == `CH_HW ||
                  r_reg.arg[1][31:24] == `CH_SW ||
                  r_reg.arg[1][31:24] == `CH_NONE) ||
                !(r_reg.arg[2][7:0] == `CH_ECHO ||
                  r_reg.arg[2][7:0] == `CH_NONE))))
            begin
              r_next.range_err = 1'b1;
            end
            else
            begin
              ps.baud = r_reg.arg[0][16:0];
              ps.parity = r_reg.arg[1][7:0];
              ps.dbits = r_reg.arg[1][11:8];
              ps.sbits = r_reg.arg[1][17:16];
              if (ptype == `PT_RS485)
              begin
                ps.tmo = r_reg.arg[2][15:0];
              end
              else
              begin
                ps.flow = r_reg.arg[1][31:24];
                ps.echo = r_reg.arg[2][7:0];
              end
              r_next.port[pi] = ps;
              r_next.apply[pi] = 1'b1;
            end
          end
          supply_cmd_pkg::OP_RES:
          begin
            r_next.unit = `UNIT_OHM;
            if (!r_reg.cmd[`CMD_HAS_ARG])
            begin
              r_next.res[0] = r_reg.rsrc;
            end
            else if (r_reg.arg[0] < RES_MIN || r_reg.arg[0] > RES_MAX)
            begin
              r_next.range_err = 1'b1;
            end
            else
            begin
              r_next.rsrc = r_reg.arg[0];
            end
          end
          supply_cmd_pkg::OP_GAIN:
          begin
            if (!r_reg.cmd[`CMD_HAS_ARG])
            begin
              r_next.st = supply_cmd_pkg::ST_GRD;
              r_next.busy = 1'b1;
              r_next.done = 1'b0;
              r_next.raddr = 4'h0;
              r_next.cnt = 4'h1;
            end
            else if (idx >= `GAIN_SETS)
            begin
              r_next.cmd_err = 1'b1;
            end
            else if (r_reg.arg[0] > `GAIN_MAX || r_reg.arg[1] > `GAIN_MAX ||
              r_reg.arg[2] > `GAIN_MAX)
            begin
              r_next.range_err = 1'b1;
            end
            else
            begin
              r_next.st = supply_cmd_pkg::ST_GWR;
              r_next.busy = 1'b1;
              r_next.done = 1'b0;
              r_next.cnt = 4'h0;
            end
          end
          supply_cmd_pkg::OP_SAVE:
          begin
            r_next.save = 1'b1;
          end
          default:
          begin
            r_next.cmd_err = 1'b1;
          end
        endcase
      end
      supply_cmd_pkg::ST_GWR:
      begin
        // one gain word per cycle: Kp, Ki, Kd
        if (r_reg.cnt == 4'h3)
        begin
          r_next.st = supply_cmd_pkg::ST_IDLE;
          r_next.busy = 1'b0;
          r_next.done = 1'b1;
        end
        else
        begin
          r_next.we = 1'b1;
          r_next.waddr = 4'(idx * 4'h3 + r_reg.cnt);
          r_next.mwdata = r_reg.arg[r_reg.cnt[1:0]][15:0];
          r_next.cnt = r_reg.cnt + 4'h1;
        end
      end
      supply_cmd_pkg::ST_GRD:
      begin
        // read data lags the address by two cycles
        r_next.raddr = r_reg.cnt;
        r_next.cnt = r_reg.cnt + 4'h1;
        if (r_reg.cnt >= 4'h2)
        begin
          r_next.res[k[3:1]][{k[0], 4'h0} +: 16] = gm.rdata;
        end
        if (r_reg.cnt == 4'hA)
        begin
          r_next.st = supply_cmd_pkg::ST_IDLE;
          r_next.busy = 1'b0;
          r_next.done = 1'b1;
        end
      end
      default:
      begin
        r_next.st = supply_cmd_pkg::ST_IDLE;
      end
    endcase
    r_next.awready = !r_next.aw_have && !r_next.bvalid;
    r_next.wready = !r_next.w_have && !r_next.bvalid;
    r_next.arready = !r_next.rvalid;
  end

  // state register
  always_ff @(posedge CLOCK)
  begin
    if (!RSTN)
    begin
      r_reg <= reset_state();
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  // outputs straight from state flops
  assign S_AXI_AWREADY = r_reg.awready;
  assign S_AXI_WREADY = r_reg.wready;
  assign S_AXI_BRESP = r_reg.bresp;
  assign S_AXI_BVALID = r_reg.bvalid;
  assign S_AXI_ARREADY = r_reg.arready;
  assign S_AXI_RDATA = r_reg.rdata;
  assign S_AXI_RRESP = r_reg.rresp;
  assign S_AXI_RVALID = r_reg.rvalid;
  assign OVP_LIMIT = r_reg.overvoltage_limit_cmd;
  assign POWER_LIMIT = r_reg.plim;
  assign POWER_TOTAL = r_reg.ptot;
  assign SOURCE_RES = r_reg.rsrc;
  assign PORT_CONFIG = r_reg.port;
  assign PORT_APPLY = r_reg.apply;
  assign SAVE_SETUP = r_reg.save;
  assign CMD_BUSY = r_reg.busy;
endmodule : supply_cmd
`default_nettype wire

//--- hdl/supply_cmd_defines.svh
`ifndef SUPPLY_CMD_DEFINES_SVH
`define SUPPLY_CMD_DEFINES_SVH

// register byte offsets
`define REG_CMD 8'h00
`define REG_ARG0 8'h04
`define REG_ARG1 8'h08
`define REG_ARG2 8'h0C
`define REG_ARG3 8'h10
`define REG_RES0 8'h14
`define REG_RES4 8'h24
`define REG_STATUS 8'h28
`define REG_EVENT 8'h2C

// command word fields
`define CMD_OP_LSB 0
`define CMD_HAS_ARG 4
`define CMD_HAS_IDX 5
`define CMD_IDX_LSB 8

// status and event bit positions
`define STAT_BUSY 0
`define STAT_DONE 1
`define STAT_ERR 2
`define STAT_UNIT_LSB 8
`define EVT_RANGE_ERR 4

// reply unit suffix characters
`define UNIT_NONE 8'h00
`define UNIT_VOLT 8'h56
`define UNIT_WATT 8'h57
`define UNIT_OHM 8'h52

// ascii codes of port settings
`define CH_ODD 8'h4F
`define CH_EVEN 8'h45
`define CH_NONE 8'h4E
`define CH_HW 8'h48
`define CH_SW 8'h53
`define CH_ECHO 8'h45
`define EMPTY_HI 32'h454D5054
`define EMPTY_LO 32'h00000059

// port type codes
`define PT_EMPTY 3'h0
`define PT_RS232 3'h1
`define PT_USB 3'h2
`define PT_RS485 3'h3
`define PT_GPIB 3'h4
`define PT_LAN 3'h5

// limits
`define OVP_NUM 35'h000000006
`define OVP_DEN 35'h000000005
`define GAIN_MAX 32'h00007530
`define GAIN_SETS 4'h3
`define TMO_MAX_MS 32'h00000064
`define PORTS 3

// port reset values
`define BAUD_RST 17'h02580
`define DBITS_RST 4'h8
`define SBITS_RST 2'h1
`define TMO_RST 16'h0001

// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- hdl/supply_cmd_pkg.sv
`include "supply_cmd_defines.svh"
package supply_cmd_pkg;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_MEASURE = 4'h1,
    OP_VERSION = 4'h2,
    OP_OVP = 4'h3,
    OP_POWER = 4'h4,
    OP_PORT = 4'h5,
    OP_RES = 4'h6,
    OP_GAIN = 4'h7,
    OP_SAVE = 4'h8
  } opcode_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_EXEC = 2'h1,
    ST_GWR = 2'h2,
    ST_GRD = 2'h3
  } state_e;

  typedef struct packed {
    logic [16:0] baud;
    logic [7:0] parity;
    logic [3:0] dbits;
    logic [1:0] sbits;
    logic [7:0] flow;
    logic [7:0] echo;
    logic [15:0] tmo;
  } port_s;

  typedef struct packed {
    state_e st;
    logic [3:0] cnt;
    logic [11:0] cmd;
    logic [3:0][31:0] arg;
    logic [4:0][31:0] res;
    logic [7:0] unit;
    logic busy;
    logic done;
    logic cmd_err;
    logic range_err;
    logic [31:0] overvoltage_limit_cmd;
    logic [31:0] plim;
    logic [31:0] ptot;
    logic [31:0] rsrc;
    port_s [2:0] port;
    logic [2:0] apply;
    logic save;
    logic aw_have;
    logic w_have;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic arready;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic we;
    logic [3:0] waddr;
    logic [15:0] mwdata;
    logic [3:0] raddr;
  } core_s;

endpackage : supply_cmd_pkg

//--- verification/axi_host.sv
`timescale 1ns/100ps
`default_nettype none
module axi_host (
  input wire logic CLOCK,
  output logic [7:0] S_AXI_AWADDR,
  output logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  output logic [31:0] S_AXI_WDATA,
  output logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  output logic S_AXI_BREADY,
  output logic [7:0] S_AXI_ARADDR,
  output logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP,
  input wire logic S_AXI_RVALID,
  output logic S_AXI_RREADY
);
  // idle bus at start
  initial
  begin
    {S_AXI_AWADDR, S_AXI_AWVALID, S_AXI_WDATA, S_AXI_WVALID} = '0;
    {S_AXI_BREADY, S_AXI_ARADDR, S_AXI_ARVALID, S_AXI_RREADY} = '0;
  end
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
    output logic [1:0] r);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge CLOCK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= v;
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
    while (!(aw && w))
    begin
      @(posedge CLOCK);
      aw = aw || S_AXI_AWREADY;
      w = w || S_AXI_WREADY;
      S_AXI_AWVALID <= !aw;
      S_AXI_WVALID <= !w;
    end
    do @(posedge CLOCK);
    while (S_AXI_BVALID !== 1'b1);
    r = S_AXI_BRESP;
    S_AXI_BREADY <= 1'b0;
  endtask : wr
  // one read
  task automatic rd(input logic [7:0] a, output logic [31:0] v,
    output logic [1:0] r);
    @(posedge CLOCK);
    S_AXI_ARADDR <= a;
    {S_AXI_ARVALID, S_AXI_RREADY} <= 2'h3;
    do @(posedge CLOCK);
    while (S_AXI_ARREADY !== 1'b1);
    S_AXI_ARVALID <= 1'b0;
    do @(posedge CLOCK);
    while (S_AXI_RVALID !== 1'b1);
    v = S_AXI_RDATA;
    r = S_AXI_RRESP;
    S_AXI_RREADY <= 1'b0;
  endtask : rd
endmodule : axi_host
`default_nettype wire

//--- verification/supply_cmd_properties.sv
`timescale 1ns/100ps
`default_nettype none
module supply_cmd_properties #(
  parameter int UNITS = 8
) (
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [3:0] UNIT_COUNT,
  input wire logic [31:0] RATED_VOLTAGE,
  input wire logic [31:0] RATED_POWER,
  input wire logic [31:0] RES_MIN,
  input wire logic [31:0] RES_MAX,
  input wire logic [31:0] OVP_LIMIT,
  input wire logic [31:0] POWER_LIMIT,
  input wire logic [31:0] POWER_TOTAL,
  input wire logic [31:0] SOURCE_RES,
  input wire logic [2:0] PORT_APPLY,
  input wire logic SAVE_SETUP
);
  default clocking @(posedge CLOCK);
  endclocking
  default disable iff (!RSTN);
  // both write channels taken at one edge
  sequence s_wr;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  // read data waiting for the master
  sequence s_rwait;
    S_AXI_RVALID && !S_AXI_RREADY;
  endsequence
  AST_BLAT: assert property (s_wr |-> ##2 S_AXI_BVALID)
    else $error("write response late");
  AST_RHOLD: assert property (s_rwait |=> $stable(S_AXI_RDATA))
    else $error("read data changed");
  AST_RLAT: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read data late");
  AST_OVP: assert property ($changed(OVP_LIMIT) |->
    {3'h0, OVP_LIMIT} * 35'h5 <= {3'h0, RATED_VOLTAGE} * 35'h6)
    else $error("protection limit out of range");
  AST_PLIM: assert property ($changed(POWER_LIMIT) |->
    POWER_LIMIT <= RATED_POWER) else $error("power limit out of range");
  AST_PTOT: assert property ($changed(POWER_LIMIT) |->
    POWER_TOTAL == UNIT_COUNT * POWER_LIMIT) else $error("power total");
  AST_RES: assert property ($changed(SOURCE_RES) |->
    SOURCE_RES >= RES_MIN && SOURCE_RES <= RES_MAX)
    else $error("source resistance out of range");
  AST_APPLY: assert property (PORT_APPLY != 3'h0 |=> PORT_APPLY == 3'h0)
    else $error("apply pulse too long");
  AST_SAVE: assert property ($rose(SAVE_SETUP) |=> !SAVE_SETUP)
    else $error("save pulse too long");
endmodule : supply_cmd_properties
bind supply_cmd supply_cmd_properties #(.UNITS(UNITS)) props (.CLOCK, .RSTN,
  .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY,
  .S_AXI_BVALID, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
  .S_AXI_RVALID, .S_AXI_RREADY, .UNIT_COUNT, .RATED_VOLTAGE, .RATED_POWER,
  .RES_MIN, .RES_MAX, .OVP_LIMIT, .POWER_LIMIT, .POWER_TOTAL, .SOURCE_RES,
  .PORT_APPLY, .SAVE_SETUP);
`default_nettype wire

//--- verification/tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "supply_cmd_defines.svh"
module tb;
  logic CLOCK = 1'b0;
  logic RSTN = 1'b0;
  logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, d;
  logic [3:0] S_AXI_WSTRB = 4'hF;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, r;
  logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
  logic S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY;
  logic S_AXI_RVALID, S_AXI_RREADY, SAVE_SETUP, CMD_BUSY;
  logic SERIES_MODE = 1'b0, saved = 1'b0;
  logic [255:0] MEAS_VOLTAGE;
  logic [3:0] UNIT_COUNT = 4'h3;
  logic [31:0] RATED_VOLTAGE = 32'h64, RATED_POWER = 32'h1F4, RES_MIN = 32'hA;
  logic [31:0] RES_MAX = 32'h32, FW_VERSION = 32'h2A, FW_DATE = 32'h20120608;
  logic [8:0] PORT_TYPE = 9'h019;
  logic [31:0] OVP_LIMIT, POWER_LIMIT, POWER_TOTAL, SOURCE_RES;
  logic [188:0] PORT_CONFIG;
  logic [2:0] PORT_APPLY, applied = 3'h0;
  int n_errors = 0, compares = 0, cycles = 0;
  supply_cmd dut (.CLOCK, .RSTN, .S_AXI_AWADDR, .S_AXI_AWVALID,
    .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY,
    .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID,
    .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY,
    .MEAS_VOLTAGE, .UNIT_COUNT, .SERIES_MODE, .RATED_VOLTAGE, .RATED_POWER,
    .RES_MIN, .RES_MAX, .FW_VERSION, .FW_DATE, .PORT_TYPE, .OVP_LIMIT,
    .POWER_LIMIT, .POWER_TOTAL, .SOURCE_RES, .PORT_CONFIG, .PORT_APPLY,
    .SAVE_SETUP, .CMD_BUSY);
  axi_host host (.CLOCK, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY,
    .S_AXI_WDATA, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID,
    .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY,
    .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY);
  always #12.5 CLOCK = !CLOCK;
  // pulse capture, timeout
  always @(posedge CLOCK)
  begin
    applied <= applied | PORT_APPLY;
    saved <= saved | SAVE_SETUP;
    cycles <= cycles + 1;
    if (cycles == 8000)
    begin
      n_errors++;
      $display("mismatch %0t timeout", $time);
      finish_test();
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    n_errors += int'(got !== exp);
    if (got !== exp)
      $display("mismatch %0t got %h exp %h", $time, got, exp);
  endtask : chk
  task automatic q(input logic [7:0] a, input logic [63:0] e);
    host.rd(a, d, r);
    chk(d, e);
  endtask : q
  // args, command, wait while busy
  task automatic go(input logic [11:0] c, input logic [31:0] a0, a1, a2);
    host.wr(`REG_ARG0, a0, r);
    host.wr(`REG_ARG1, a1, r);
    host.wr(`REG_ARG2, a2, r);
    host.wr(`REG_CMD, {20'h0, c}, r);
    do host.rd(`REG_STATUS, d, r);
    while (d[0] !== 1'b0);
  endtask : go
  task automatic t_meas;
    go(12'h001, 0, 0, 0);
    chk(d[15:8], `UNIT_VOLT);
    q(`REG_RES0, 32'h100);
    go(12'h221, 0, 0, 0);
    q(`REG_RES0, 32'h102);
    SERIES_MODE <= 1'b1;
    go(12'h001, 0, 0, 0);
    q(`REG_RES0, 32'h303);
    go(12'h002, 0, 0, 0);
    q(`REG_RES0, 32'h2A);
    q(8'h18, 32'h20120608);
    host.wr(8'h40, 0, r);
    chk(r, `RESP_SLVERR);
  endtask : t_meas
  task automatic t_lim;
    go(12'h013, 32'h78, 0, 0);
    chk(OVP_LIMIT, 32'h78);
    go(12'h013, 32'h79, 0, 0);
    q(`REG_EVENT, 32'h10);
    go(12'h003, 0, 0, 0);
    q(`REG_RES0, 32'h78);
    host.wr(`REG_EVENT, 32'h10, r);
    go(12'h014, 32'h1F4, 0, 0);
    chk(POWER_TOTAL, 32'h5DC);
    go(12'h014, 32'h1F5, 0, 0);
    chk(POWER_LIMIT, 32'h1F4);
    host.wr(`REG_EVENT, 32'h10, r);
    go(12'h016, 32'h9, 0, 0);
    q(`REG_EVENT, 32'h10);
    chk(SOURCE_RES, 32'h0);
    host.wr(`REG_EVENT, 32'h10, r);
  endtask : t_lim
  task automatic t_port;
    go(12'h135, 32'h1C200, 32'h4E02084E, 32'h45);
    chk(PORT_CONFIG[62:0], {17'h1C200, 8'h4E, 4'h8, 2'h2, 8'h4E, 8'h45,
      16'h1});
    chk(applied, 3'h1);
    go(12'h125, 0, 0, 0);
    q(8'h18, 32'h1C200);
    go(12'h235, 32'h2580, 32'h0001084E, 32'h32);
    chk(PORT_CONFIG[78:63], 16'h32);
    go(12'h235, 32'h2581, 32'h0001084E, 32'h32);
    q(`REG_EVENT, 32'h10);
    go(12'h325, 0, 0, 0);
    q(8'h18, `EMPTY_HI);
    PORT_TYPE <= 9'h119;
    go(12'h335, 32'h2580, 32'h0001084E, 32'h45);
    chk(d[2], 1'b1);
    PORT_TYPE <= 9'h099;
    go(12'h335, 32'h4B0, 32'h4801074F, 32'h4E);
    chk(PORT_CONFIG[188:126], {17'h4B0, 8'h4F, 4'h7, 2'h1, 8'h48, 8'h4E,
      16'h1});
  endtask : t_port
  task automatic t_gain;
    host.wr(`REG_EVENT, 32'h10, r);
    go(12'h037, 32'h7530, 32'h1, 32'h2);
    go(12'h007, 0, 0, 0);
    q(`REG_RES0, 32'h00017530);
    go(12'h037, 32'h7531, 0, 0);
    q(`REG_EVENT, 32'h10);
    go(12'h008, 0, 0, 0);
    chk(saved, 1'b1);
  endtask : t_gain
  task automatic finish_test;
    if (n_errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test
  // unit readings, reset, then the scenarios
  initial
  begin
    for (int u = 0; u < 8; u++)
      MEAS_VOLTAGE[u*32+:32] = 32'h100 + u;
    repeat (10) @(posedge CLOCK);
    RSTN <= 1'b1;
    t_meas();
    t_lim();
    t_port();
    t_gain();
    finish_test();
  end
endmodule : tb
`default_nettype wire
